//--- pkg/ocsd_cfg.svh
`ifndef OCSD_CFG_SVH
`define OCSD_CFG_SVH
// ****************************************************************
// register byte addresses
// ****************************************************************
`define OCSD_ADDR_CTRL 8'h00
`define OCSD_ADDR_DIV 8'h04
`define OCSD_ADDR_FBD 8'h08
`define OCSD_ADDR_TUNE 8'h0c
`define OCSD_ADDR_KEY 8'h10
// ****************************************************************
// field positions
// ****************************************************************
`define OCSD_CUR_LSB 12
`define OCSD_NEXT_LSB 8
`define OCSD_CLKLK_BIT 7
`define OCSD_PINLK_BIT 6
`define OCSD_PLLLK_BIT 5
`define OCSD_FAIL_BIT 3
`define OCSD_SECEN_BIT 1
`define OCSD_SWREQ_BIT 0
`define OCSD_RECOV_BIT 15
`define OCSD_DOZE_LSB 12
`define OCSD_REDEN_BIT 11
`define OCSD_FRCDV_LSB 8
`define OCSD_POST_LSB 6
`define OCSD_PRE_LSB 0
// ****************************************************************
// reset values and timing
// ****************************************************************
`define OCSD_DOZE_RST 3'h3
`define OCSD_FRCDV_RST 3'h0
`define OCSD_POST_RST 2'h1
`define OCSD_PRE_RST 5'h00
`define OCSD_MULT_RST 9'h030
`define OCSD_TRIM_RST 6'h00
`define OCSD_SETTLE_TICKS 4'ha
`endif

//--- pkg/ocsd_pkg.sv
`default_nettype none
package ocsd_pkg;
	// switch sequencer states
	typedef enum logic [1:0] {
		OCSD_IDLE,
		OCSD_WAIT_READY,
		OCSD_SETTLE
	} ocsd_state_t;
	// clock source encoding
	typedef logic [2:0] ocsd_src_t;
endpackage : ocsd_pkg
`default_nettype wire

//--- rtl/ocsd_top.sv
`include "ocsd_cfg.svh"
`default_nettype none
module ocsd_top #(
	parameter logic [7:0] KEY_FIRST = 8'h5a, // arbitrary unlock key
	parameter logic [7:0] KEY_SECOND = 8'ha5 // arbitrary unlock key
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic rst,
	// other resets, clear only the unlock progress
	input wire logic warm_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration straps
	input wire logic [2:0] cfg_initial_source,
	input wire logic cfg_switch_enable,
	input wire logic cfg_monitor_enable,
	// oscillator and pll status
	input wire logic osc_ready,
	input wire logic pll_lock_in,
	input wire logic new_clk_tick,
	input wire logic fail_detect,
	input wire logic interrupt_in,
	// clock controls
	output logic [2:0] current_source,
	output logic secondary_osc_enable,
	output logic pps_write_allow,
	output logic switch_busy,
	output logic [2:0] doze_ratio,
	output logic [2:0] fast_rc_postscaler,
	output logic [1:0] pll_output_divider,
	output logic [4:0] pll_input_divider,
	output logic [8:0] pll_feedback_multiplier,
	output logic [5:0] fast_rc_trim
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// sources routed through the pll
	function automatic logic uses_pll(input ocsd_pkg::ocsd_src_t s);
		uses_pll = (s == 3'h1) || (s == 3'h3);
	endfunction : uses_pll

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] wd, input logic [3:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	// ****************************************************************
	// register state
	// ****************************************************************

	ocsd_pkg::ocsd_src_t cur_src_reg; // active source
	ocsd_pkg::ocsd_src_t next_src_reg; // switch target
	logic clk_lock_reg; // source lock
	logic pin_lock_reg; // pin select lock
	logic pll_lock_reg; // pll lock status
	logic fail_reg; // sticky clock fail
	logic sec_en_reg; // secondary oscillator on
	logic sw_req_reg; // switch in progress
	logic [15:0] div_reg; // clock divisor image
	logic [8:0] mult_reg; // feedback multiplier
	logic [5:0] trim_reg; // fast rc trim
	logic [1:0] key_reg; // unlock progress
	logic [31:0] rdata_reg; // read data
	logic [3:0] tick_cnt_reg; // new clock ticks seen
	ocsd_pkg::ocsd_state_t state_reg;

	// ****************************************************************
	// bus decode
	// ****************************************************************

	logic setup_ph; // first apb cycle
	logic wr_en; // write commits
	logic hit_ctrl, hit_div, hit_fbd, hit_tune, hit_key;
	logic ctrl_wr; // unlocked control write
	logic lane0, lane1; // strobes for low and high byte
	logic sw_allowed; // switching possible now
	logic sw_start; // new request accepted
	logic redundant; // request to current source

	assign setup_ph = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign hit_ctrl = (paddr == `OCSD_ADDR_CTRL);
	assign hit_div = (paddr == `OCSD_ADDR_DIV);
	assign hit_fbd = (paddr == `OCSD_ADDR_FBD);
	assign hit_tune = (paddr == `OCSD_ADDR_TUNE);
	assign hit_key = (paddr == `OCSD_ADDR_KEY);
	// writes to control need a completed key pair
	assign ctrl_wr = wr_en && hit_ctrl && (key_reg == 2'h2);
	assign lane0 = ctrl_wr && pstrb[0];
	assign lane1 = ctrl_wr && pstrb[1];
	// lock only bites when switching on and monitor off
	assign sw_allowed = cfg_switch_enable &&
		!(clk_lock_reg && !cfg_monitor_enable);
	assign sw_start = lane0 && pwdata[`OCSD_SWREQ_BIT] && sw_allowed
		&& !sw_req_reg;
	assign redundant = next_src_reg == cur_src_reg;

	// zero wait states: read data is captured in setup
	assign pready = 1'b1;
	// unmapped address answers with an error in access
	assign pslverr = psel && penable &&
		!(hit_ctrl || hit_div || hit_fbd || hit_tune || hit_key);
	assign prdata = rdata_reg;

	// ****************************************************************
	// unlock sequence
	// ****************************************************************

	// two key writes arm a single control write; any other write clears the progress
	always_ff @(posedge clk) begin
		if (rst || warm_rst) begin
			key_reg <= 2'h0;
		end else if (wr_en && hit_key) begin
			if (pwdata[7:0] == KEY_FIRST) begin
				key_reg <= 2'h1;
			end else if (pwdata[7:0] == KEY_SECOND && key_reg == 2'h1) begin
				key_reg <= 2'h2;
			end else begin
				key_reg <= 2'h0;
			end
		end else if (wr_en) begin
			// one write consumes the unlock, used or not
			key_reg <= 2'h0;
		end
	end

	// ****************************************************************
	// oscillator control fields
	// ****************************************************************

	// next source loads from straps at power-on only
	always_ff @(posedge clk) begin
		if (rst) begin
			next_src_reg <= cfg_initial_source;
		end else if (lane1) begin
			next_src_reg <= pwdata[`OCSD_NEXT_LSB +: 3];
		end
	end

	// lock bits and secondary enable live in the low byte
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_lock_reg <= 1'b0;
			pin_lock_reg <= 1'b0;
			sec_en_reg <= 1'b0;
		end else if (lane0) begin
			clk_lock_reg <= pwdata[`OCSD_CLKLK_BIT];
			pin_lock_reg <= pwdata[`OCSD_PINLK_BIT];
			sec_en_reg <= pwdata[`OCSD_SECEN_BIT];
		end
	end

	// clock fail: detection wins over a software clear
	always_ff @(posedge clk) begin
		if (rst) begin
			fail_reg <= 1'b0;
		end else if (fail_detect) begin
			fail_reg <= 1'b1;
		end else if (lane0 && !pwdata[`OCSD_FAIL_BIT]) begin
			fail_reg <= 1'b0;
		end
	end

	// lock flag low while pll unused or settling
	always_ff @(posedge clk) begin
		if (rst) begin
			pll_lock_reg <= 1'b0;
		end else if (sw_start) begin
			pll_lock_reg <= 1'b0;
		end else begin
			pll_lock_reg <= pll_lock_in && (uses_pll(cur_src_reg) ||
				(sw_req_reg && uses_pll(next_src_reg)));
		end
	end

	// ****************************************************************
	// switch sequencer
	// ****************************************************************

	// request, start-up wait, settle count, then commit
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ocsd_pkg::OCSD_IDLE;
			sw_req_reg <= 1'b0;
			tick_cnt_reg <= 4'h0;
			cur_src_reg <= cfg_initial_source;
		end else if (!cfg_switch_enable) begin
			// switching off: request pinned low
			state_reg <= ocsd_pkg::OCSD_IDLE;
			sw_req_reg <= 1'b0;
			tick_cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				ocsd_pkg::OCSD_IDLE: begin
					tick_cnt_reg <= 4'h0;
					if (sw_start && redundant) begin
						sw_req_reg <= 1'b0;
					end else if (sw_start) begin
						sw_req_reg <= 1'b1;
						state_reg <= ocsd_pkg::OCSD_WAIT_READY;
					end
				end
				ocsd_pkg::OCSD_WAIT_READY: begin
					// target must run, and lock if pll fed
					if (osc_ready && (!uses_pll(next_src_reg) || pll_lock_in)) begin
						state_reg <= ocsd_pkg::OCSD_SETTLE;
					end
				end
				ocsd_pkg::OCSD_SETTLE: begin
					if (new_clk_tick) begin
						if (tick_cnt_reg == `OCSD_SETTLE_TICKS - 4'h1) begin
							// commit: copy target, drop request
							cur_src_reg <= next_src_reg;
							sw_req_reg <= 1'b0;
							state_reg <= ocsd_pkg::OCSD_IDLE;
						end else begin
							tick_cnt_reg <= tick_cnt_reg + 4'h1;
						end
					end
				end
				default: begin
					state_reg <= ocsd_pkg::OCSD_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// divisor, feedback and trim registers
	// ****************************************************************

	// divisor; an interrupt with recovery set clears reduction enable over a write
	always_ff @(posedge clk) begin
		if (rst) begin
			div_reg <= {1'b0, `OCSD_DOZE_RST, 1'b0, `OCSD_FRCDV_RST,
				`OCSD_POST_RST, 1'b0, `OCSD_PRE_RST};
		end else begin
			if (wr_en && hit_div) begin
				div_reg <= merge16(div_reg, pwdata, pstrb) & 16'hffdf;
			end
			if (interrupt_in && div_reg[`OCSD_RECOV_BIT]) begin
				div_reg[`OCSD_REDEN_BIT] <= 1'b0;
			end
		end
	end

	// feedback multiplier, nine bits
	always_ff @(posedge clk) begin
		if (rst) begin
			mult_reg <= `OCSD_MULT_RST;
		end else if (wr_en && hit_fbd) begin
			// top bit rides in lane 1, the rest in lane 0
			mult_reg[8] <= pstrb[1] ? pwdata[8] : mult_reg[8];
			mult_reg[7:0] <= pstrb[0] ? pwdata[7:0] : mult_reg[7:0];
		end
	end

	// fast rc trim, signed six bits
	always_ff @(posedge clk) begin
		if (rst) begin
			trim_reg <= `OCSD_TRIM_RST;
		end else if (wr_en && hit_tune && pstrb[0]) begin
			trim_reg <= pwdata[5:0];
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************

	// captured in setup so data is a flop in access
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			if (hit_ctrl) begin
				rdata_reg <= {17'h00000, cur_src_reg, 1'b0, next_src_reg,
					clk_lock_reg, pin_lock_reg, pll_lock_reg, 1'b0,
					fail_reg, 1'b0, sec_en_reg, sw_req_reg};
			end else if (hit_div) begin
				rdata_reg <= {16'h0000, div_reg};
			end else if (hit_fbd) begin
				rdata_reg <= {23'h000000, mult_reg};
			end else if (hit_tune) begin
				rdata_reg <= {26'h0000000, trim_reg};
			end else begin
				rdata_reg <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	assign current_source = cur_src_reg;
	assign secondary_osc_enable = sec_en_reg;
	assign pps_write_allow = !pin_lock_reg;
	assign switch_busy = sw_req_reg;
	// ratio falls to 1:1 when reduction is off
	assign doze_ratio = div_reg[`OCSD_REDEN_BIT] ?
		div_reg[`OCSD_DOZE_LSB +: 3] : 3'h0;
	assign fast_rc_postscaler = div_reg[`OCSD_FRCDV_LSB +: 3];
	// code 10 is passed through; software must not use it
	assign pll_output_divider = div_reg[`OCSD_POST_LSB +: 2];
	assign pll_input_divider = div_reg[`OCSD_PRE_LSB +: 5];
	assign pll_feedback_multiplier = mult_reg;
	assign fast_rc_trim = trim_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// last settle tick seen
	sequence s_last_tick;
		state_reg == ocsd_pkg::OCSD_SETTLE && new_clk_tick &&
			tick_cnt_reg == `OCSD_SETTLE_TICKS - 4'h1 && cfg_switch_enable;
	endsequence

	// request accepted toward another source
	sequence s_valid_start;
		state_reg == ocsd_pkg::OCSD_IDLE && sw_start && !redundant &&
			cfg_switch_enable;
	endsequence

	AST_SWITCH_COMMIT: assert property (s_last_tick |=>
		cur_src_reg == $past(next_src_reg) && !sw_req_reg)
		else $error("switch did not commit after settle");
	AST_SWITCH_HOLD: assert property (s_valid_start |=>
		sw_req_reg && state_reg == ocsd_pkg::OCSD_WAIT_READY)
		else $error("valid request not held");
	AST_REDUNDANT: assert property (state_reg == ocsd_pkg::OCSD_IDLE &&
		sw_start && redundant && cfg_switch_enable |=> !sw_req_reg)
		else $error("redundant request not aborted");
	AST_SWITCH_OFF: assert property (!cfg_switch_enable |=> !sw_req_reg)
		else $error("request set while switching disabled");
	AST_FAIL_STICKY: assert property (fail_detect ##1 (!lane0)[*3]
		|-> fail_reg)
		else $error("clock fail flag lost");
	AST_RECOVER_CLEAR: assert property (interrupt_in && div_reg[`OCSD_RECOV_BIT]
		|=> doze_ratio == 3'h0)
		else $error("interrupt did not restore 1:1");
	AST_LOCKED_WRITE: assert property (wr_en && hit_ctrl && key_reg != 2'h2
		|=> $stable(next_src_reg) && $stable(clk_lock_reg))
		else $error("control changed without unlock");
	AST_PIN_LOCK: assert property ($past(lane0) ?
		pps_write_allow == !$past(pwdata[`OCSD_PINLK_BIT]) : $stable(pps_write_allow))
		else $error("pin select lock misbehaves");
	AST_POR_MULT: assert property ($fell(rst) |-> mult_reg == `OCSD_MULT_RST &&
		pll_output_divider == `OCSD_POST_RST)
		else $error("power-on values wrong");
	AST_CLK_LOCK: assert property (clk_lock_reg && !cfg_monitor_enable &&
		!sw_req_reg |=> !sw_req_reg)
		else $error("switch accepted while source locked");

endmodule : ocsd_top
`default_nettype wire

//--- dv/ocsd_osc_model.sv
`default_nettype none
// ****
// oscillator and pll stand-in
// ****
module ocsd_osc_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// switch in flight, start-up speed
	input wire logic busy,
	input wire logic slow,
	// status toward the controller
	output logic osc_ready,
	output logic pll_lock_in,
	output logic new_clk_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_reg; // cycles since switch start
	logic [1:0] tick_reg; // new clock runs at a third of clk
	// timers only run while a switch is pending
	always_ff @(posedge clk) begin
		if (rst || !busy) begin
			cnt_reg <= 8'h00;
			tick_reg <= 2'h0;
		end else begin
			cnt_reg <= cnt_reg + {7'h0, ~&cnt_reg};
			tick_reg <= (tick_reg == 2'h2) ? 2'h0 : tick_reg + 2'h1;
		end
	end
	// slow start-up makes the controller really wait
	assign osc_ready = busy && (cnt_reg >= (slow ? 8'h28 : 8'h03));
	// relocks on every switch, so a pll target sees lock late
	always_ff @(posedge clk) begin
		if (rst) begin
			pll_lock_in <= 1'b0;
		end else if (busy) begin
			pll_lock_in <= cnt_reg >= (slow ? 8'h3c : 8'h05);
		end
	end
	assign new_clk_tick = busy && tick_reg == 2'h0;
endmodule : ocsd_osc_model
`default_nettype wire

//--- dv/ocsd_top_tb.sv
`include "ocsd_cfg.svh"
`default_nettype none
// ****
// register bench for the clock controller
// ****
module ocsd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] KEY_A = 8'h3c; // arbitrary key
	localparam logic [7:0] KEY_B = 8'hc3; // arbitrary key
	logic clk = 1'b0, rst = 1'b1, warm_rst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [2:0] cfg_initial_source = 3'h2;
	logic cfg_switch_enable = 1'b1, cfg_monitor_enable = 1'b0;
	logic fail_detect = 1'b0, interrupt_in = 1'b0, slow = 1'b0;
	logic osc_ready, pll_lock_in, new_clk_tick, pready, pslverr;
	logic [31:0] prdata, r;
	logic [2:0] current_source, doze_ratio, fast_rc_postscaler, cs, ns;
	logic secondary_osc_enable, pps_write_allow, switch_busy;
	logic [1:0] pll_output_divider;
	logic [4:0] pll_input_divider;
	logic [8:0] pll_feedback_multiplier;
	logic [5:0] fast_rc_trim;
	logic [7:0] lo; // expected control low byte
	logic [32:0] expq[$]; // pending reads, error flag on top
	int err_count = 0, n_tests = 0;
	always #2 clk = ~clk;
	ocsd_top #(.KEY_FIRST(KEY_A), .KEY_SECOND(KEY_B)) ocsd_top_inst (
		.clk, .rst, .warm_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .cfg_initial_source, .cfg_switch_enable,
		.cfg_monitor_enable, .osc_ready, .pll_lock_in, .new_clk_tick, .fail_detect,
		.interrupt_in, .current_source, .secondary_osc_enable, .pps_write_allow,
		.switch_busy, .doze_ratio, .fast_rc_postscaler, .pll_output_divider,
		.pll_input_divider, .pll_feedback_multiplier, .fast_rc_trim);
	ocsd_osc_model ocsd_osc_model_inst (.clk, .rst, .busy(switch_busy), .slow,
		.osc_ready, .pll_lock_in, .new_clk_tick);
	// ****
	// checking
	// ****
	task automatic fail_msg(input string m);
		err_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail_msg
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) fail_msg($sformatf("port %h exp %h", g, e));
	endtask : chk
	task automatic chk_rd(input logic [32:0] e);
		n_tests++;
		if ({pslverr, prdata} !== e) fail_msg($sformatf("read %h exp %h", {pslverr, prdata}, e));
	endtask : chk_rd
	// oldest note is matched at each completed read
	always @(posedge clk) begin
		if ((psel & penable & pready & ~pwrite) === 1'b1) begin
			if (expq.size() == 0) fail_msg("unexpected read");
			else chk_rd(expq.pop_front());
		end
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	// ****
	// bus tasks
	// ****
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0, 4'h0);
	endtask : rd
	// key pair right before the control write
	task automatic uw(input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, `OCSD_ADDR_KEY, {24'h0, KEY_A}, 4'h1);
		apb(1'b1, `OCSD_ADDR_KEY, {24'h0, KEY_B}, 4'h1);
		apb(1'b1, `OCSD_ADDR_CTRL, d, s);
	endtask : uw
	task automatic rdc;
		rd(`OCSD_ADDR_CTRL, {18'h0, cs, 1'b0, ns, lo});
	endtask : rdc
	// divisor write, readback and decoded outputs
	task automatic dv(input logic [15:0] d);
		apb(1'b1, `OCSD_ADDR_DIV, {16'h0, d}, 4'h3);
		rd(`OCSD_ADDR_DIV, {17'h0, d & 16'hffdf});
		chk(doze_ratio, d[11] ? d[14:12] : 3'h0);
		chk(fast_rc_postscaler, d[10:8]);
		chk(pll_output_divider, d[7:6]);
		chk(pll_input_divider, d[4:0]);
	endtask : dv
	// switch request; go says whether it must run
	task automatic sw(input logic [2:0] n, input logic go);
		int t = 0; // new clock ticks seen while busy
		uw({21'h0, n, 8'h00}, 4'h2);
		ns = n;
		uw({24'h0, lo | 8'h01}, 4'h1);
		repeat (2) @(posedge clk);
		chk(switch_busy, go);
		for (int i = 0; i < 500 && switch_busy === 1'b1; i++) begin
			@(posedge clk);
			t = t + int'(new_clk_tick === 1'b1);
		end
		cs = go ? n : cs;
		@(negedge clk);
		chk(switch_busy, 1'b0);
		chk(current_source, cs);
		chk(go ? t >= `OCSD_SETTLE_TICKS : t == 0, 1'b1);
	endtask : sw
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(73));
		cs = 3'h2;
		ns = 3'h2;
		lo = 8'h00;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cfg_initial_source <= 3'h5; // strap only counts during power-on
		rdc();
		rd(`OCSD_ADDR_DIV, {17'h0, 16'h3040});
		rd(`OCSD_ADDR_FBD, 33'h030);
		rd(`OCSD_ADDR_TUNE, 33'h0);
		rd(8'h14, {1'b1, 32'h0}); // unmapped place
		chk(current_source, 3'h2);
		// boundaries first, then random values
		for (int i = 0; i < 6; i++) begin
			r = (i == 0) ? 32'h1ff : (i == 1) ? 32'h20 : $urandom;
			apb(1'b1, `OCSD_ADDR_FBD, r, 4'h3);
			apb(1'b1, `OCSD_ADDR_TUNE, r, 4'h3);
			rd(`OCSD_ADDR_FBD, {24'h0, r[8:0]});
			rd(`OCSD_ADDR_TUNE, {27'h0, r[5:0]});
			chk(pll_feedback_multiplier, r[8:0]);
			chk(fast_rc_trim, r[5:0]);
			dv(r[31:16]);
		end
		// interrupt with and without recovery
		dv(16'hd800);
		@(posedge clk) interrupt_in <= 1'b1;
		@(posedge clk) interrupt_in <= 1'b0;
		@(negedge clk);
		chk(doze_ratio, 3'h0);
		rd(`OCSD_ADDR_DIV, {17'h0, 16'hd000});
		dv(16'h5800);
		@(posedge clk) interrupt_in <= 1'b1;
		@(posedge clk) interrupt_in <= 1'b0;
		@(negedge clk);
		chk(doze_ratio, 3'h5);
		// switches, pll modes reached only through plain fast rc
		sw(3'h0, 1'b1);
		rdc();
		slow <= 1'b1;
		sw(3'h1, 1'b1);
		lo = 8'h20;
		rdc();
		lo = 8'h80;
		slow <= 1'b0;
		uw({24'h0, lo}, 4'h1);
		sw(3'h0, 1'b0);
		@(posedge clk) cfg_monitor_enable <= 1'b1;
		sw(3'h0, 1'b1);
		@(posedge clk) cfg_monitor_enable <= 1'b0;
		@(posedge clk) cfg_switch_enable <= 1'b0;
		sw(3'h2, 1'b0);
		@(posedge clk) cfg_switch_enable <= 1'b1;
		lo = 8'h00;
		sw(3'h0, 1'b0);
		rdc();
		// enables, pin lock and the sticky fail flag
		lo = 8'h42;
		uw({24'h0, lo}, 4'h1);
		@(negedge clk);
		chk(secondary_osc_enable, 1'b1);
		chk(pps_write_allow, 1'b0);
		@(posedge clk) fail_detect <= 1'b1;
		@(posedge clk) fail_detect <= 1'b0;
		repeat (5) @(posedge clk);
		lo = 8'h4a;
		rdc();
		apb(1'b1, `OCSD_ADDR_CTRL, 32'h0, 4'h1);
		rdc();
		apb(1'b1, `OCSD_ADDR_KEY, {24'h0, KEY_A}, 4'h1);
		apb(1'b1, `OCSD_ADDR_KEY, {24'h0, KEY_B}, 4'h1);
		@(posedge clk) warm_rst <= 1'b1;
		@(posedge clk) warm_rst <= 1'b0;
		apb(1'b1, `OCSD_ADDR_CTRL, 32'h0, 4'h1);
		rdc();
		rd(`OCSD_ADDR_DIV, {17'h0, 16'h5800});
		lo = 8'h00;
		uw(32'h0, 4'h1);
		rdc();
		chk(pps_write_allow, 1'b1);
		chk(secondary_osc_enable, 1'b0);
		summarize();
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		fail_msg("timeout");
		summarize();
	end
endmodule : ocsd_top_tb
`default_nettype wire
